// ### rtl/pmdx_top.sv
// Purpose: phy side of a 10/100 mii with carrier, collision and crossover
// Assumes: speed, duplex, link and management bits come from sys_clk logic
// Notes: 100M line coding lives outside; pcs_* carry its nibbles
//
// Summary of operation
// - 10M full duplex: no transmit loopback into receive, no heartbeat test.
// - full duplex: carrier only from receive activity, collision held low.
// - half duplex: carrier while transmitting or receiving.
// - half duplex: collision when receive activity meets own transmission.
// - crossover enabled and no link: swap transmit and receive pairs.
// - crossover off by enable pin or management code; both ends obey.
// - crossover independent of negotiation and settles before it starts.
// - crossover comes up enabled after reset.
// - mii moves framed 4-bit nibbles each way at 10 or 100 Mbps.
// - device sources both transmit and receive clocks to the mac.
// - mac drives txd, tx_en, tx_er; device drives rxd, rx_dv, rx_er.
// - during power-on reset mii and line transmit outputs are isolated.
// - after reset the mii and line transmit outputs are driven.
// - 10M mode manchester-codes nibbles onto the line and back.
`timescale 1ns/1ps
`default_nettype none
`include "pmdx_params.svh"

module pmdx_top
    import pmdx_pkg::*;
#(
    parameter int XOVER_CYC = `PMDX_XOVER_CYC,
    parameter int SQE_DLY = `PMDX_SQE_DLY,
    parameter int SQE_END = `PMDX_SQE_END
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic por_busy,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic link_up,
    input wire logic [1:0] mgmt_xover_ctl,
    input wire logic crossover_enable_pin,
    input wire pmdx_mii_tx_s mii_tx,
    output logic mii_tx_clk,
    output logic mii_rx_clk,
    output pmdx_mii_rx_s mii_rx,
    output logic mii_crs,
    output logic mii_col,
    output logic mii_oe,
    input wire logic line_rx_in,
    input wire logic line_alt_in,
    output logic line_tx_pos,
    output logic line_tx_neg,
    output logic line_alt_pos,
    output logic line_alt_neg,
    output logic line_oe,
    input wire logic pcs_rx_clk,
    input wire pmdx_mii_rx_s pcs_rx,
    output pmdx_mii_tx_s pcs_tx,
    output logic mdix_swap,
    output logic an_go
);

pmdx_top_s q;
pmdx_top_s d;
pmdx_pins_s pins;

logic [4:0] half_c;
logic tick;
logic fall;
logic hd10;
logic rx_pair;
logic dec_in;
logic tx_load;
logic tx_bit;
logic tx_busy;
logic rx_act;
logic xen;
logic iso;
logic [3:0] dec_nib;
logic dec_vld;
logic dec_act;

// every pin from outside the clock domain, first sync stage
assign pins.por = por_busy;
assign pins.xen = crossover_enable_pin;
assign pins.mtx = mii_tx;
assign pins.lrx = line_rx_in;
assign pins.lalt = line_alt_in;
assign pins.pclk = pcs_rx_clk;
assign pins.prx = pcs_rx;

// one divider makes both mii clocks, so tx and rx stay in phase
assign half_c = speed_100 ? 5'(`PMDX_HALF100) : 5'(`PMDX_HALF10);
assign tick = (q.div >= half_c - 5'h1);
assign fall = tick & q.mclk;

assign hd10 = !full_duplex && !speed_100;
assign rx_pair = q.swap ? q.s2.lalt : q.s2.lrx;
// half duplex 10M echoes own frame into the decoder, full duplex does not
assign dec_in = (hd10 && tx_busy) ? tx_bit : rx_pair;
// sampled mid-period, well away from the mac's launch edge
assign tx_load = fall && !speed_100 && q.s2.mtx.en;
assign rx_act = speed_100 ? q.hold.dv : q.line_act;
assign xen = q.s2.xen && (mgmt_xover_ctl != `PMDX_XOVER_OFF);
assign iso = q.s2.por;

pmdx_man_tx u_mtx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(tx_load),
    .nib(q.s2.mtx.txd),
    .bit_q(tx_bit),
    .busy_q(tx_busy)
);

pmdx_man_rx u_mrx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(dec_in),
    .nib_q(dec_nib),
    .vld_q(dec_vld),
    .act_q(dec_act)
);

always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.pclk_d = q.s2.pclk;

    // nibble clock generation
    if (tick) begin
        d.div = 5'h0;
        d.mclk = ~q.mclk;
    end else begin
        d.div = q.div + 5'h1;
    end

    // 100M receive nibbles are caught on the pcs clock's rising edge
    if (q.s2.pclk && !q.pclk_d) begin
        d.hold = q.s2.prx;
    end
    if (dec_vld) begin
        d.r10 = dec_nib;
    end

    // line activity on the real receive pair, never the echo
    // counts down so the all-zero reset reads as a quiet line
    d.rxp_d = rx_pair;
    if (rx_pair != q.rxp_d) begin
        d.act_cnt = 5'(`PMDX_IDLE_CYC);
    end else if (q.act_cnt != 5'h00) begin
        d.act_cnt = q.act_cnt - 5'h01;
    end
    d.line_act = (q.act_cnt != 5'h00);

    // heartbeat window counter
    if (q.sqe != 8'h00) begin
        d.sqe = (q.sqe == 8'(SQE_END)) ? 8'h00 : q.sqe + 8'h01;
    end

    // mii transfers: rx changes on the falling edge, mac samples on rising
    if (fall) begin
        d.tx_act = q.s2.mtx.en;
        if (speed_100 && q.s2.mtx.en) begin
            d.ptx = q.s2.mtx;
        end else begin
            d.ptx = '0;
        end
        if (speed_100) begin
            d.mrx = q.hold;
        end else begin
            // a nibble finished this cycle is not yet
            d.mrx.rxd = dec_vld ? dec_nib : q.r10;
            d.mrx.dv = dec_act;
            d.mrx.er = 1'b0;
        end
        // heartbeat only after a half duplex 10M transmission
        if (hd10 && q.tx_act && !q.s2.mtx.en) begin
            d.sqe = 8'h01;
        end
    end

    // carrier and collision from the resolved duplex
    if (full_duplex) begin
        d.crs = rx_act;
        d.col = 1'b0;
    end else begin
        d.crs = rx_act | q.tx_act;
        d.col = (q.tx_act && rx_act) || (q.sqe > 8'(SQE_DLY));
    end

    // 10M line drive, onto whichever pair the crossover chose
    d.ltp = !q.swap && tx_busy && tx_bit;
    d.ltn = !q.swap && tx_busy && !tx_bit;
    d.lap = q.swap && tx_busy && tx_bit;
    d.lan = q.swap && tx_busy && !tx_bit;

    // hot insertion: hold the mii and line outputs off while power-on reset runs
    d.mii_oe = !iso;
    d.line_oe = !iso;
    if (iso) begin
        d.mrx = '0;
        d.crs = 1'b0;
        d.col = 1'b0;
    end

    // crossover hunt, runs with no regard to negotiation state
    unique case (q.xs)
        pmdx_xs_seek: begin
            d.an_go = 1'b0;
            if (!xen) begin
                d.xs = pmdx_xs_off;
                d.swap = 1'b0;
            end else if (link_up || q.line_act) begin
                d.xs = pmdx_xs_lock;
                d.xcnt = 24'h000000;
            end else if (q.xcnt == 24'(XOVER_CYC - 1)) begin
                d.xcnt = 24'h000000;
                d.swap = ~q.swap;
            end else begin
                d.xcnt = q.xcnt + 24'h000001;
            end
        end
        pmdx_xs_lock: begin
            d.an_go = 1'b1;
            if (!xen) begin
                d.xs = pmdx_xs_off;
                d.swap = 1'b0;
            end else if (link_up || q.line_act) begin
                d.xcnt = 24'h000000;
            end else if (q.xcnt == 24'(XOVER_CYC - 1)) begin
                // a whole dwell with no link and no energy: hunt again
                d.xs = pmdx_xs_seek;
                d.xcnt = 24'h000000;
            end else begin
                d.xcnt = q.xcnt + 24'h000001;
            end
        end
        pmdx_xs_off: begin
            d.an_go = 1'b1;
            d.swap = 1'b0;
            d.xcnt = 24'h000000;
            if (xen) begin
                d.xs = pmdx_xs_seek;
                d.an_go = 1'b0;
            end
        end
        default: begin
            d.xs = pmdx_xs_seek;
        end
    endcase
end

// zero reset puts the hunt in seek, so crossover starts enabled
always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
        q <= `PMDX_RST_VAL;
    end else begin
        q <= d;
    end
end

assign mii_tx_clk = q.mclk;
assign mii_rx_clk = q.mclk;
assign mii_rx = q.mrx;
assign mii_crs = q.crs;
assign mii_col = q.col;
assign mii_oe = q.mii_oe;
assign line_tx_pos = q.ltp;
assign line_tx_neg = q.ltn;
assign line_alt_pos = q.lap;
assign line_alt_neg = q.lan;
assign line_oe = q.line_oe;
assign pcs_tx = q.ptx;
assign mdix_swap = q.swap;
assign an_go = q.an_go;

endmodule // pmdx_top
`default_nettype wire

// ### common/pmdx_params.svh
// Purpose: timing counts, field codes and reset values for the phy mii block
// Assumes: sys_clk at 100 MHz
// Notes: cycle counts are derived from a time in ns and the clock rate, except the decoder windows
`ifndef PMDX_PARAMS_SVH
`define PMDX_PARAMS_SVH

`define PMDX_CLK_MHZ 100
// nibble clock periods, 25 MHz and 2.5 MHz
`define PMDX_NIB100_NS 40
`define PMDX_NIB10_NS 400
`define PMDX_HALF100 ((`PMDX_NIB100_NS * `PMDX_CLK_MHZ) / 2000)
`define PMDX_HALF10 ((`PMDX_NIB10_NS * `PMDX_CLK_MHZ) / 2000)
// 10M half-bit time, 50 ns
`define PMDX_HALF_BIT_NS 50
`define PMDX_HALF_CYC ((`PMDX_HALF_BIT_NS * `PMDX_CLK_MHZ) / 1000)
// decoder windows in cycles: least gap for a mid-bit edge, idle timeout
`define PMDX_MID_MIN 7
`define PMDX_IDLE_CYC 15
// heartbeat after end of transmit: delay then window
`define PMDX_SQE_DLY_NS 1000
`define PMDX_SQE_LEN_NS 1000
`define PMDX_SQE_DLY ((`PMDX_SQE_DLY_NS * `PMDX_CLK_MHZ + 999) / 1000)
`define PMDX_SQE_END (`PMDX_SQE_DLY + (`PMDX_SQE_LEN_NS * `PMDX_CLK_MHZ) / 1000)
// dwell time on one pair assignment while hunting, 1 ms
`define PMDX_XOVER_NS 1000000
`define PMDX_XOVER_CYC ((`PMDX_XOVER_NS / 1000) * `PMDX_CLK_MHZ)
// management control code that turns crossover off
`define PMDX_XOVER_OFF 2'b01
`define PMDX_RST_VAL '0

`endif

// ### common/pmdx_pkg.sv
// Purpose: shared types of the phy mii block
// Assumes: nothing beyond the params header
// Notes: seek state is code zero so an all-zero reset enables crossover
package pmdx_pkg;

typedef struct packed {
    logic [3:0] txd;
    logic en;
    logic er;
} pmdx_mii_tx_s;

typedef struct packed {
    logic [3:0] rxd;
    logic dv;
    logic er;
} pmdx_mii_rx_s;

typedef enum logic [1:0] {
    pmdx_xs_seek = 2'b00,
    pmdx_xs_off = 2'b01,
    pmdx_xs_lock = 2'b10
} pmdx_xs_e;

typedef struct packed {
    logic por;
    logic xen;
    pmdx_mii_tx_s mtx;
    logic lrx;
    logic lalt;
    logic pclk;
    pmdx_mii_rx_s prx;
} pmdx_pins_s;

typedef struct packed {
    logic [3:0] sh;
    logic [2:0] half;
    logic [3:0] cnt;
    logic busy;
    logic lvl;
} pmdx_mtx_s;

typedef struct packed {
    logic prev;
    logic [4:0] cnt;
    logic aligned;
    logic last;
    logic [3:0] sh;
    logic [1:0] bidx;
    logic [3:0] nib;
    logic vld;
} pmdx_mrx_s;

typedef struct packed {
    pmdx_pins_s s1;
    pmdx_pins_s s2;
    logic pclk_d;
    logic [4:0] div;
    logic mclk;
    pmdx_mii_rx_s hold;
    logic [3:0] r10;
    pmdx_mii_rx_s mrx;
    pmdx_mii_tx_s ptx;
    logic rxp_d;
    logic [4:0] act_cnt;
    logic line_act;
    logic tx_act;
    logic [7:0] sqe;
    logic crs;
    logic col;
    logic mii_oe;
    logic line_oe;
    logic ltp;
    logic ltn;
    logic lap;
    logic lan;
    pmdx_xs_e xs;
    logic [23:0] xcnt;
    logic swap;
    logic an_go;
} pmdx_top_s;

endpackage

// ### rtl/pmdx_man_tx.sv
// Purpose: 10M nibble serialiser with manchester coding
// Assumes: load arrives once per nibble period, 8 half-bits long
// Notes: lsb first; line idles low once the shifter runs dry
`timescale 1ns/1ps
`default_nettype none
`include "pmdx_params.svh"

module pmdx_man_tx
    import pmdx_pkg::*;
#(
    parameter int HALF = `PMDX_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [3:0] nib,
    output logic bit_q,
    output logic busy_q
);

pmdx_mtx_s q;
pmdx_mtx_s d;

always_comb begin
    d = q;
    if (load) begin
        d.sh = nib;
        d.half = 3'h0;
        d.cnt = 4'h0;
        d.busy = 1'b1;
        d.lvl = ~nib[0];
    end else if (q.busy) begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(HALF - 1)) begin
            d.cnt = 4'h0;
            d.half = q.half + 3'h1;
            if (!q.half[0]) begin
                d.lvl = q.sh[0];
            end else begin
                d.sh = {1'b0, q.sh[3:1]};
                d.lvl = ~q.sh[1];
                if (q.half == 3'h7) begin
                    d.busy = 1'b0;
                    d.lvl = 1'b0;
                end
            end
        end
    end
end

always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
        q <= `PMDX_RST_VAL;
    end else begin
        q <= d;
    end
end

assign bit_q = q.lvl;
assign busy_q = q.busy;

endmodule // pmdx_man_tx
`default_nettype wire

// ### rtl/pmdx_man_rx.sv
// Purpose: 10M manchester decoder and nibble deserialiser
// Assumes: din is already synchronised to sys_clk
// Notes: hunts for the two ones that close the preamble before framing
`timescale 1ns/1ps
`default_nettype none
`include "pmdx_params.svh"

module pmdx_man_rx
    import pmdx_pkg::*;
#(
    parameter int MID = `PMDX_MID_MIN,
    parameter int IDLE = `PMDX_IDLE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic [3:0] nib_q,
    output logic vld_q,
    output logic act_q
);

pmdx_mrx_s q;
pmdx_mrx_s d;

always_comb begin
    d = q;
    d.vld = 1'b0;
    d.prev = din;
    if (q.cnt != 5'(IDLE)) begin
        d.cnt = q.cnt + 5'h1;
    end
    // edges nearer than MID are bit-boundary edges and carry no data
    if ((din ^ q.prev) && q.cnt >= 5'(MID)) begin
        d.cnt = 5'h0;
        if (!q.aligned) begin
            // once framed, last marks that a first nibble is out
            d.last = din & !(q.last & din);
            d.aligned = q.last & din;
            d.bidx = 2'h0;
        end else begin
            d.sh = {din, q.sh[3:1]};
            d.bidx = q.bidx + 2'h1;
            if (q.bidx == 2'h3) begin
                d.nib = {din, q.sh[3:1]};
                d.vld = 1'b1;
                d.last = 1'b1;
            end
        end
    end else if (q.cnt == 5'(IDLE)) begin
        d.aligned = 1'b0;
        d.last = 1'b0;
    end
end

always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
        q <= `PMDX_RST_VAL;
    end else begin
        q <= d;
    end
end

assign nib_q = q.nib;
assign vld_q = q.vld;
// valid rises with the first data nibble, never on a stale one
assign act_q = q.aligned & q.last;

endmodule // pmdx_man_rx
`default_nettype wire

// ### dv/pmdx_top_sva.sv
// Purpose: port checker for pmdx_top
// Assumes: a 60 cycle hold covers sync, nibble and register latency
// Notes: bound onto pmdx_top at the foot
`timescale 1ns/1ps
`default_nettype none
module pmdx_top_sva
    import pmdx_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic por_busy,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic link_up,
    input wire logic [1:0] mgmt_xover_ctl,
    input wire logic crossover_enable_pin,
    input wire pmdx_mii_tx_s mii_tx,
    input wire pmdx_mii_rx_s pcs_rx,
    input wire pmdx_mii_rx_s mii_rx,
    input wire logic mii_crs,
    input wire logic mii_col,
    input wire logic mii_oe,
    input wire logic line_oe,
    input wire logic mdix_swap,
    input wire logic an_go
);
    logic xok, hd, fd;
    logic [7:0] tx_q, both_q, fd_q;
    assign xok = crossover_enable_pin && mgmt_xover_ctl != 2'b01;
    assign hd = !sys_rst && mii_oe && !full_duplex;
    assign fd = !sys_rst && mii_oe && full_duplex && speed_100;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // saturating hold counters; isolation clears them
    always_ff @(posedge sys_clk) begin
        tx_q <= (hd && mii_tx.en) ? tx_q + {7'h00, !tx_q[7]} : 8'h00;
        both_q <= (hd && speed_100 && mii_tx.en && pcs_rx.dv) ? both_q + {7'h00, !both_q[7]} : 8'h00;
        fd_q <= (fd && !pcs_rx.dv) ? fd_q + {7'h00, !fd_q[7]} : 8'h00;
    end
    sequence por_held;
        por_busy [*4];
    endsequence
    sequence locked;
        (xok && link_up) [*6];
    endsequence
    a_iso_por: assert property (por_held |=> !mii_oe && !line_oe && mii_rx == '0 && !mii_crs)
        else $error("outputs not isolated in power-on reset");
    a_oe_up: assert property ((!por_busy) [*4] |=> mii_oe && line_oe)
        else $error("outputs not driven after reset");
    a_hd_crs: assert property (tx_q > 8'd60 |-> mii_crs)
        else $error("no carrier while transmitting");
    a_hd_col: assert property (both_q > 8'd60 |-> mii_col && mii_crs)
        else $error("no collision on receive during transmit");
    a_fd_col: assert property (full_duplex [*3] |-> !mii_col)
        else $error("collision in full duplex");
    a_fd_crs: assert property (fd_q > 8'd60 |-> !mii_crs)
        else $error("carrier without receive in full duplex");
    a_xover_off: assert property ((!xok) [*4] |=> !mdix_swap && an_go)
        else $error("crossover not off");
    a_lock_hold: assert property (locked |=> $stable(mdix_swap) && an_go)
        else $error("pairs moved with link up");
endmodule // pmdx_top_sva
bind pmdx_top pmdx_top_sva u_sva (.*);
`default_nettype wire

// ### dv/pmdx_mac_model.sv
// Purpose: mac side of the mii transmit path
// Assumes: both clocks come from the phy
// Notes: txd shows the inverse of its last value once released
`timescale 1ns/1ps
`default_nettype none
module pmdx_mac_model
    import pmdx_pkg::*;
(
    input wire logic mii_tx_clk,
    input wire logic mii_oe,
    output var pmdx_mii_tx_s mii_tx
);
    initial mii_tx = '0;
    // only after the phy clock rises, never while isolated
    task automatic send(input logic [3:0] nib[$], input int gap);
        wait (mii_oe === 1'b1);
        repeat (gap) @(posedge mii_tx_clk);
        foreach (nib[i]) begin
            @(posedge mii_tx_clk);
            #1 mii_tx = '{txd: nib[i], en: 1'b1, er: 1'b0};
        end
        @(posedge mii_tx_clk);
        #1 mii_tx = '{txd: ~mii_tx.txd, en: 1'b0, er: 1'b0};
    endtask
endmodule // pmdx_mac_model
`default_nettype wire

// ### dv/test_phy_mii_duplex_crossover.sv
// Purpose: self-checking bench for the phy mii block
// Assumes: crossover dwell cut to 50 cycles, line inputs idle
// Notes: neighbouring nibbles differ, so a held nibble is taken once
`timescale 1ns/1ps
`default_nettype none
module test_phy_mii_duplex_crossover
    import pmdx_pkg::*;
;
    localparam int XOVER = 50;
    logic sys_clk, sys_rst, por_busy, speed_100, full_duplex, link_up, xen_pin, pclk;
    logic txc, rxc, col, moe, loe, swap, ango, sqe_seen, dv_seen;
    logic [1:0] xctl;
    logic [3:0] last_rx;
    logic [3:0] exp_q[$];
    pmdx_mii_rx_s prx, mrx;
    pmdx_mii_tx_s mtx;
    int mismatches, num_checks;

    pmdx_top #(.XOVER_CYC(XOVER)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .por_busy(por_busy),
        .speed_100(speed_100), .full_duplex(full_duplex), .link_up(link_up), .mgmt_xover_ctl(xctl),
        .crossover_enable_pin(xen_pin), .mii_tx(mtx), .mii_tx_clk(txc), .mii_rx_clk(rxc), .mii_rx(mrx),
        .mii_crs(), .mii_col(col), .mii_oe(moe), .line_rx_in(1'b0), .line_alt_in(1'b0), .line_tx_pos(),
        .line_tx_neg(), .line_alt_pos(), .line_alt_neg(), .line_oe(loe), .pcs_rx_clk(pclk), .pcs_rx(prx),
        .pcs_tx(), .mdix_swap(swap), .an_go(ango));
    pmdx_mac_model mac (.mii_tx_clk(txc), .mii_oe(moe), .mii_tx(mtx));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic mk(input int n, ref logic [3:0] q[$]);
        logic [3:0] v;
        repeat (n) begin
            v = 4'($urandom());
            if (q.size() > 0 && v === q[$]) begin
                v = ~v;
            end
            q.push_back(v);
        end
    endtask
    // link clock runs only inside a frame, plus one clock with dv low to end it
    task automatic pcs_send(input int n);
        logic [3:0] q[$];
        mk(n, q);
        foreach (q[i]) begin
            prx = '{rxd: q[i], dv: 1'b1, er: 1'b0};
            exp_q.push_back(q[i]);
            #62.5 pclk = 1'b1;
            #62.5 pclk = 1'b0;
        end
        prx = '{rxd: ~prx.rxd, dv: 1'b0, er: 1'b0};
        #62.5 pclk = 1'b1;
        #62.5 pclk = 1'b0;
    endtask
    always @(posedge rxc) begin
        if (mrx.dv === 1'b1) begin
            dv_seen = 1'b1;
            if (mrx.rxd !== last_rx && exp_q.size() > 0) begin
                check(mrx.rxd, exp_q.pop_front());
            end
        end
        last_rx = (mrx.dv === 1'b1) ? mrx.rxd : 4'hx;
    end
    always @(posedge sys_clk) begin
        if (col === 1'b1) begin
            sqe_seen = 1'b1;
        end
    end
    initial begin
        #500000;
        mismatches++;
        $display("ERROR %0t run hung", $time);
        final_report();
    end
    initial begin
        logic [3:0] d[$];
        logic [3:0] tx[$];
        logic s;
        sys_rst = 1'b1;
        por_busy = 1'b0;
        speed_100 = 1'b1;
        full_duplex = 1'b0;
        link_up = 1'b0;
        xen_pin = 1'b1;
        xctl = 2'b00;
        pclk = 1'b0;
        prx = '0;
        last_rx = 4'hx;
        mismatches = 0;
        num_checks = 0;
        void'($urandom(32'hd6b23b21));
        tick(20);
        sys_rst = 1'b0;
        tick(10);
        check(ango, 1'b0);
        s = swap;
        tick(XOVER + 5);
        check(swap ^ s, 1'b1);
        tick(XOVER);
        check(swap ^ s, 1'b0);
        for (int k = 0; k < 2; k++) begin
            xen_pin = k[0];
            xctl = k[0] ? 2'b01 : 2'b00;
            tick(6);
            check({swap, ango}, 2'b01);
        end
        xctl = 2'b00;
        tick(6);
        check(ango, 1'b0);
        link_up = 1'b1;
        tick(6);
        s = swap;
        check(ango, 1'b1);
        tick(2 * XOVER);
        check(swap ^ s, 1'b0);
        for (int m = 0; m < 4; m++) begin
            speed_100 = m[1];
            full_duplex = m[0];
            d.delete();
            tx.delete();
            mk(20, d);
            repeat (15) tx.push_back(4'h5);
            tx.push_back(4'hd);
            tx = {tx, d};
            if (m == 0) begin
                exp_q = d;
            end
            tick(100);
            dv_seen = 1'b0;
            if (m[1]) begin
                fork
                    mac.send(tx, 0);
                    pcs_send(24);
                join
            end else begin
                mac.send(tx, $urandom_range(3, 0));
            end
            tick(60);
            sqe_seen = 1'b0;
            tick(300);
            if (!m[1]) begin
                check(dv_seen, !m[0]);
                check(sqe_seen, !m[0]);
            end
            check(4'(exp_q.size()), 4'h0);
            exp_q.delete();
        end
        por_busy = 1'b1;
        tick(6);
        check({moe, loe}, 2'b00);
        por_busy = 1'b0;
        tick(6);
        check({moe, loe}, 2'b11);
        final_report();
    end
endmodule // test_phy_mii_duplex_crossover
`default_nettype wire
